// ### src/rscl_defs.svh
// Constants for the startup configuration loader
`ifndef RSCL_DEFS_SVH
`define RSCL_DEFS_SVH
`define RSCL_BIT_XSEL_LO 0
`define RSCL_BIT_XSEL_HI 1
`define RSCL_BIT_RESV_A 2
`define RSCL_BIT_POL_SQ 3
`define RSCL_BIT_RESV_B 4
`define RSCL_BIT_TXR_N 5
`define RSCL_BIT_COLL_SEL 6
`define RSCL_BIT_DISP_MAX 7
`define RSCL_CFG_RESET 8'h34
`define RSCL_COLL_LIMIT_0 6'h3f
`define RSCL_COLL_LIMIT_1 6'h1f
`define RSCL_TEST_TIME_MS 1000
`define RSCL_CLK_KHZ 20000
`define RSCL_TEST_CYCLES (`RSCL_TEST_TIME_MS * `RSCL_CLK_KHZ)
`endif

// ### src/rscl_pkg.sv
// Types for the startup configuration loader
package rscl_pkg;
  typedef enum logic [1:0] {
    RSCL_HOLD = 2'b00,
    RSCL_TEST = 2'b01,
    RSCL_RUN = 2'b10
  } rscl_state_type;
  typedef enum logic [1:0] {
    RSCL_PIN_CFG = 2'b00,
    RSCL_PIN_DISPLAY = 2'b01,
    RSCL_PIN_CPU = 2'b10
  } rscl_pin_use_type;
endpackage : rscl_pkg

// ### src/rscl_sync.sv
// Two-stage synchroniser for a pin level
`timescale 1ns/10ps
`default_nettype none
module rscl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= INIT;
      s2_r <= INIT;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule : rscl_sync
`default_nettype wire

// ### src/rscl_loader.sv
// Startup configuration capture, reset hold and display test timer
//
// How it works
// RULE_01: Pins shared by load, display, processor use
// RULE_02: Load input low holds timers in reset
// RULE_03: Load rising edge captures data pins
// RULE_04: Without processor, pull resistors set pins
// RULE_05: With processor, decoded write strobe loads
// RULE_06: Two select bits map ports two-seven
// RULE_07: Bit set enables polarity squelch switching
// RULE_08: Bit clear applies transmit-only restriction
// RULE_09: Collision limit 63 or 31
// RULE_10: Display bit picks minimum or maximum
// RULE_11: Reserved bit positions must be one
// RULE_12: One second display test, no repetition
`timescale 1ns/10ps
`default_nettype none
`include "rscl_defs.svh"
module rscl_loader #(
  parameter int TEST_CYCLES = `RSCL_TEST_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic config_load_reset_n_i,
  input wire logic [7:0] data_pins_i,
  input wire logic display_busy_i,
  input wire logic cpu_access_i,
  output logic core_reset_o,
  output logic repeat_enable_o,
  output logic led_test_o,
  output logic [5:0] port_internal_o,
  output logic polarity_squelch_switch_en_o,
  output logic transmit_only_partition_n_o,
  output logic [5:0] collision_limit_o,
  output logic display_max_mode_o,
  output logic config_error_o,
  output logic [7:0] startup_configuration_o,
  output logic [1:0] pin_use_o
);
  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers; data pins settle before the strobe rises
  logic load_n_s;
  logic [7:0] data_s;
  rscl_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_load (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(config_load_reset_n_i),
    .q_o(load_n_s)
  );
  rscl_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_data (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(data_pins_i),
    .q_o(data_s)
  );
  //////////////////////////////////////////////////////////////////////
  // State and configuration
  rscl_pkg::rscl_state_type state_r, state_nxt;
  logic load_n_d_r, load_n_d_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic rise;
  assign rise = load_n_s & ~load_n_d_r;
  // Next-state: low load input forces hold, edge captures config
  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    cnt_nxt = cnt_r;
    load_n_d_nxt = load_n_s;
    if (!load_n_s) begin
      state_nxt = rscl_pkg::RSCL_HOLD; // see RULE_02
      cnt_nxt = '0;
    end else if (rise) begin
      // Pin level captured by resistors or write strobe; see RULE_04
      cfg_nxt = data_s; // see RULE_03 see RULE_05
      state_nxt = rscl_pkg::RSCL_TEST; // see RULE_12
      cnt_nxt = '0;
    end else begin
      case (state_r)
        rscl_pkg::RSCL_HOLD: begin
          state_nxt = rscl_pkg::RSCL_HOLD;
        end
        rscl_pkg::RSCL_TEST: begin
          if (cnt_r >= 32'(TEST_CYCLES - 1)) begin
            state_nxt = rscl_pkg::RSCL_RUN; // see RULE_12
          end else begin
            cnt_nxt = cnt_r + 32'd1;
          end
        end
        rscl_pkg::RSCL_RUN: begin
          state_nxt = rscl_pkg::RSCL_RUN;
        end
        default: begin
          state_nxt = rscl_pkg::RSCL_HOLD;
        end
      endcase
    end
  end
  // Pure registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= rscl_pkg::RSCL_HOLD;
      cfg_r <= `RSCL_CFG_RESET;
      cnt_r <= '0;
      load_n_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      cnt_r <= cnt_nxt;
      load_n_d_r <= load_n_d_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Decoded outputs, all registered
  logic [5:0] int_nxt;
  logic [1:0] xsel;
  logic [1:0] use_nxt;
  assign xsel = {cfg_nxt[`RSCL_BIT_XSEL_HI], cfg_nxt[`RSCL_BIT_XSEL_LO]};
  // Bit k of the map is port k+2; internal when high
  always_comb begin
    case (xsel)
      2'b00: int_nxt = 6'h00; // see RULE_06
      2'b01: int_nxt = 6'h3c; // see RULE_06
      2'b10: int_nxt = 6'h30; // see RULE_06
      default: int_nxt = 6'h3f; // see RULE_06
    endcase
  end
  // Pin owner; configuration owns pins while load input is low
  always_comb begin
    if (state_nxt == rscl_pkg::RSCL_HOLD) begin
      use_nxt = rscl_pkg::RSCL_PIN_CFG; // see RULE_01
    end else if (cpu_access_i && !display_busy_i) begin
      use_nxt = rscl_pkg::RSCL_PIN_CPU; // see RULE_01
    end else begin
      use_nxt = rscl_pkg::RSCL_PIN_DISPLAY; // see RULE_01
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      repeat_enable_o <= 1'b0;
      led_test_o <= 1'b0;
      port_internal_o <= 6'h00;
      polarity_squelch_switch_en_o <= 1'b0;
      // Follows the reset byte, restriction off, so checks agree at release
      transmit_only_partition_n_o <= 1'b1;
      collision_limit_o <= `RSCL_COLL_LIMIT_0;
      display_max_mode_o <= 1'b0;
      config_error_o <= 1'b0;
      startup_configuration_o <= `RSCL_CFG_RESET;
      pin_use_o <= rscl_pkg::RSCL_PIN_CFG;
    end else begin
      core_reset_o <= (state_nxt == rscl_pkg::RSCL_HOLD); // see RULE_02
      repeat_enable_o <= (state_nxt == rscl_pkg::RSCL_RUN); // see RULE_12
      led_test_o <= (state_nxt == rscl_pkg::RSCL_TEST); // see RULE_12
      port_internal_o <= int_nxt;
      polarity_squelch_switch_en_o <= cfg_nxt[`RSCL_BIT_POL_SQ]; // see RULE_07
      transmit_only_partition_n_o <= cfg_nxt[`RSCL_BIT_TXR_N]; // see RULE_08
      collision_limit_o <= cfg_nxt[`RSCL_BIT_COLL_SEL] ?
        `RSCL_COLL_LIMIT_1 : `RSCL_COLL_LIMIT_0; // see RULE_09
      display_max_mode_o <= cfg_nxt[`RSCL_BIT_DISP_MAX]; // see RULE_10
      // Flag reserved zeros; hardware still runs, see RULE_11
      config_error_o <= ~(cfg_nxt[`RSCL_BIT_RESV_A] &
        cfg_nxt[`RSCL_BIT_RESV_B]);
      startup_configuration_o <= cfg_nxt;
      pin_use_o <= use_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Checks
  logic [1:0] xsel_o;
  assign xsel_o = {startup_configuration_o[`RSCL_BIT_XSEL_HI],
    startup_configuration_o[`RSCL_BIT_XSEL_LO]};
  property p_hold_reset;
    @(posedge clk_i) disable iff (rst_i)
      !load_n_s |=> core_reset_o && !repeat_enable_o;
  endproperty
  a_hold_reset: assert property (p_hold_reset) // see RULE_02
    else $error("core not held in reset while load low");
  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
      rise |=> startup_configuration_o == $past(data_s);
  endproperty
  a_capture: assert property (p_capture) // see RULE_03
    else $error("config not captured on load edge");
  property p_map;
    @(posedge clk_i) disable iff (rst_i)
      port_internal_o == (xsel_o == 2'b00 ? 6'h00 : xsel_o == 2'b01 ?
        6'h3c : xsel_o == 2'b10 ? 6'h30 : 6'h3f);
  endproperty
  a_map: assert property (p_map) // see RULE_06
    else $error("port map wrong");
  property p_pol;
    @(posedge clk_i) disable iff (rst_i)
      polarity_squelch_switch_en_o ==
        startup_configuration_o[`RSCL_BIT_POL_SQ];
  endproperty
  a_pol: assert property (p_pol) // see RULE_07
    else $error("polarity switch bit wrong");
  property p_tx_restrict;
    @(posedge clk_i) disable iff (rst_i)
      transmit_only_partition_n_o ==
        startup_configuration_o[`RSCL_BIT_TXR_N];
  endproperty
  a_tx_restrict: assert property (p_tx_restrict) // see RULE_08
    else $error("transmit-only bit wrong");
  property p_coll;
    @(posedge clk_i) disable iff (rst_i)
      collision_limit_o == (startup_configuration_o[`RSCL_BIT_COLL_SEL] ?
        6'd31 : 6'd63);
  endproperty
  a_coll: assert property (p_coll) // see RULE_09
    else $error("collision limit wrong");
  property p_disp;
    @(posedge clk_i) disable iff (rst_i)
      display_max_mode_o == startup_configuration_o[`RSCL_BIT_DISP_MAX];
  endproperty
  a_disp: assert property (p_disp) // see RULE_10
    else $error("display mode wrong");
  property p_test;
    @(posedge clk_i) disable iff (rst_i)
      rise |=> led_test_o && !repeat_enable_o;
  endproperty
  a_test: assert property (p_test) // see RULE_12
    else $error("led test not started on load edge");
  property p_no_rep;
    @(posedge clk_i) disable iff (rst_i)
      led_test_o |-> !repeat_enable_o && !core_reset_o;
  endproperty
  a_no_rep: assert property (p_no_rep) // see RULE_12
    else $error("repetition during led test");
  property p_pins;
    @(posedge clk_i) disable iff (rst_i)
      core_reset_o |-> pin_use_o == rscl_pkg::RSCL_PIN_CFG;
  endproperty
  a_pins: assert property (p_pins) // see RULE_01
    else $error("pins not in config use during load");
  c_load: cover property (@(posedge clk_i) disable iff (rst_i) rise);
  c_run: cover property (@(posedge clk_i) disable iff (rst_i)
    led_test_o ##1 repeat_enable_o);
  c_bad: cover property (@(posedge clk_i) disable iff (rst_i)
    config_error_o);
endmodule : rscl_loader
`default_nettype wire

// ### verif/rscl_host_model.sv
// Host strobe and pull network model that drives the load and data pins
`timescale 1ns/10ps
`default_nettype none
module rscl_host_model (
  input wire logic clk_i,
  output logic load_n_o,
  output logic [7:0] data_o
);
  // Power-on level: load pin held low by the network
  initial begin
    load_n_o = 1'b0;
    data_o = 8'h14;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Return the pin low, ending any run
  task automatic hold_low();
    @(posedge clk_i);
    load_n_o <= 1'b0;
  endtask : hold_low
  // Decoded write: data set up while strobe low, rise, then bus driven to the inverse
  task automatic write_cfg(input logic [7:0] val, input int low_cycles);
    @(posedge clk_i);
    data_o <= val;
    load_n_o <= 1'b0;
    repeat (low_cycles) @(posedge clk_i);
    load_n_o <= 1'b1;
    // Inverse after hold, so stale data never looks valid
    fork
      begin
        repeat (4) @(posedge clk_i);
        data_o <= ~val;
      end
    join_none
  endtask : write_cfg
endmodule : rscl_host_model
`default_nettype wire

// ### verif/rscl_loader_bench.sv
// Self-checking bench for the startup configuration loader
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
  fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module rscl_loader_bench;
  localparam int TC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic busy = 1'b0;
  logic cpu = 1'b1;
  wire logic load_n;
  wire logic [7:0] pins;
  wire logic core_rst, rpt, led;
  wire logic pol, txn, disp, err;
  wire logic [5:0] ports, coll;
  wire logic [7:0] cfg;
  wire logic [1:0] use_o;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [5:0] map_exp [4] = '{6'h00, 6'h3c, 6'h30, 6'h3f};
  logic [7:0] vec [5] = '{8'h14, 8'h3d, 8'h56, 8'hbf, 8'hc3};
  rscl_host_model host (.clk_i(clk_i), .load_n_o(load_n), .data_o(pins));
  rscl_loader #(.TEST_CYCLES(TC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .config_load_reset_n_i(load_n),
    .data_pins_i(pins), .display_busy_i(busy), .cpu_access_i(cpu),
    .core_reset_o(core_rst), .repeat_enable_o(rpt), .led_test_o(led),
    .port_internal_o(ports), .polarity_squelch_switch_en_o(pol),
    .transmit_only_partition_n_o(txn), .collision_limit_o(coll),
    .display_max_mode_o(disp), .config_error_o(err),
    .startup_configuration_o(cfg), .pin_use_o(use_o));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a hang guard well past the expected run
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  // One load, then check the answer, the test period and the return to hold
  task automatic load_check(input logic [7:0] v, input logic b);
    int n;
    @(posedge clk_i);
    busy <= b;
    cpu <= v[1];
    host.write_cfg(v, 3);
    n = 0;
    while (led !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("test start", 1'b1, led)
    `CHK("timers free", 1'b0, core_rst)
    `CHK("pin owner", (!b && v[1]) ? 2'h2 : 2'h1, use_o)
    `CHK("ports", map_exp[v[1:0]], ports)
    `CHK("pol sq", v[3], pol)
    `CHK("tx only", v[5], txn)
    `CHK("coll", v[6] ? 6'h1f : 6'h3f, coll)
    `CHK("disp", v[7], disp)
    `CHK("resv err", ~(v[2] & v[4]), err)
    n = 0;
    // Repetition must stay off for the whole test period
    while (led === 1'b1 && n < 40) begin
      `CHK("no repeat", 1'b0, rpt)
      @(negedge clk_i);
      n++;
    end
    `CHK("test length", TC, n)
    `CHK("repeat on", 1'b1, rpt)
    // Data pins were inverted after the edge and must be ignored
    `CHK("cfg kept", v, cfg)
    host.hold_low();
    repeat (5) @(negedge clk_i);
    `CHK("hold", 1'b1, core_rst)
    `CHK("hold rpt", 1'b0, rpt)
  endtask : load_check
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("rst core", 1'b1, core_rst)
    `CHK("rst cfg", 8'h34, cfg)
    `CHK("rst coll", 6'h3f, coll)
    `CHK("rst txn", 1'b1, txn)
    // Release on the fifth rising edge, like every other input
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK("idle hold", 1'b1, core_rst)
    `CHK("idle led", 1'b0, led)
    for (int i = 0; i < 5; i++) begin
      load_check(vec[i], i[0] ^ 1'b1);
    end
    test_done();
  end
endmodule : rscl_loader_bench
`default_nettype wire
